//--- hdl/ssr_cfg.svh
// Offsets, field positions, reset values and sizes of the sample store registers.
// Assumes word addressing on a seven-bit register port.
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

`define SSR_ADDR_W      7
`define SSR_DATA_W      32
`define SSR_SLOT_COUNT  64
`define SSR_SLOT_IDX_W  6
`define SSR_OFF_SLOT0   7'h00
`define SSR_OFF_SLOTN   7'h3f
`define SSR_OFF_ENABLE  7'h40
`define SSR_OFF_STATUS  7'h41
`define SSR_SAMPLE_W    12
`define SSR_ADC1_LSB    0
`define SSR_ADC2_LSB    16
`define SSR_BIT_DONE    0
`define SSR_RST_ENABLE  1'b0
`define SSR_RST_STATUS  1'b1
`define SSR_RST_SAMPLE  12'h000

`endif

//--- hdl/ssr_pkg.sv
// Types shared by the sample store register bank.
// Assumes ssr_cfg.svh is on the include path.
`include "ssr_cfg.svh"

package ssr_pkg;

   // One register port request, word addressed
   typedef struct packed {
      logic [`SSR_ADDR_W-1:0]     address;
      logic                       read;
      logic                       write;
      logic [`SSR_DATA_W-1:0]     writedata;
   } ssr_csr_req_t;

   // One conversion response from the sequencer side
   typedef struct packed {
      logic                       valid;
      logic [`SSR_SLOT_IDX_W-1:0] slot;
      logic [`SSR_SAMPLE_W-1:0]   adc1;
      logic [`SSR_SAMPLE_W-1:0]   adc2;
      logic                       eop;
   } ssr_rsp_t;

endpackage : ssr_pkg

//--- hdl/ssr_sample_store.sv
// Sample store register bank: 64 slot result words, block-done enable and flag, irq.
// Assumes responses come from logic on sys_clk, and the register port master is on sys_clk.
//
// Overview of operation
// R1: Sixty-four result words, slot n at offset n
// R2: Single build: 12-bit value, upper bits zero
// R3: Dual build: second at 27:16, first 11:0
// R4: Offset 0x40 bit0 enable, reset zero
// R5: Cleared enable keeps flag off irq
// R6: Flag visible in status regardless of enable
// R7: Offset 0x41 flag, one-cycle pulse, resets one
// R8: Seven-bit word address, strobes, 32-bit data
// R9: Single interrupt request output
// R10: One clock, one active-low reset
// R11: Irq exactly when flag and enable
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_sample_store #(
   parameter int SLOTS = `SSR_SLOT_COUNT,
   parameter bit DUAL  = 1'b0
) (
   input  wire logic                   sys_clk,
   input  wire logic                   srst_n,
   input  wire ssr_pkg::ssr_csr_req_t  csr,
   output logic [`SSR_DATA_W-1:0]      readdata,
   input  wire ssr_pkg::ssr_rsp_t      rsp,
   output logic                        irq
);
   import ssr_pkg::*;

   localparam int SAMPLE_W = `SSR_SAMPLE_W;
   localparam int IDX_W    = `SSR_SLOT_IDX_W;

   logic [SAMPLE_W-1:0] slot_adc1 [SLOTS];
   logic [SAMPLE_W-1:0] slot_adc2 [SLOTS];
   logic                block_done_enable;
   logic                block_done_flag;
   logic                next_enable;
   logic                next_flag;
   logic [`SSR_DATA_W-1:0] next_readdata;
   logic                hit_slot;
   logic                hit_enable;
   logic                hit_status;

   // Writes reach only the enable word; slots and status ignore them
   assign hit_slot   = (csr.address <= `SSR_OFF_SLOTN);
   assign hit_enable = (csr.address == `SSR_OFF_ENABLE);
   assign hit_status = (csr.address == `SSR_OFF_STATUS);

   // Slot results; each entry latches its own response
   for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      always_ff @(posedge sys_clk) begin
         if (!srst_n) begin // see R10
            slot_adc1[s] <= `SSR_RST_SAMPLE;
            slot_adc2[s] <= `SSR_RST_SAMPLE;
         end else if (rsp.valid && rsp.slot == IDX_W'(s)) begin // see R1
            slot_adc1[s] <= rsp.adc1;
            slot_adc2[s] <= DUAL ? rsp.adc2 : `SSR_RST_SAMPLE;
         end
      end
   end

   // Enable register, software owned
   always_comb begin
      next_enable = block_done_enable;
      if (csr.write && hit_enable) begin // see R4
         next_enable = csr.writedata[`SSR_BIT_DONE];
      end
   end

   // Flag only lives one cycle, so a write-one-clear has nothing left to do
   always_comb begin
      next_flag = rsp.valid && rsp.eop; // see R7
   end

   always_ff @(posedge sys_clk) begin
      if (!srst_n) begin
         block_done_enable <= `SSR_RST_ENABLE; // see R4
         block_done_flag   <= `SSR_RST_STATUS; // see R7
      end else begin
         block_done_enable <= next_enable;
         block_done_flag   <= next_flag;   // see R6
      end
   end

   // Registered from the same next values, so irq never lags the flag
   always_ff @(posedge sys_clk) begin
      if (!srst_n) begin
         irq <= `SSR_RST_STATUS & `SSR_RST_ENABLE;
      end else begin
         irq <= next_flag & next_enable; // see R5, see R9, see R11
      end
   end

   // Read mux; unmapped offsets answer zero
   always_comb begin
      next_readdata = '0;
      if (hit_slot) begin
         next_readdata[`SSR_ADC1_LSB +: SAMPLE_W] =
            slot_adc1[csr.address[`SSR_SLOT_IDX_W-1:0]]; // see R2
         if (DUAL) begin
            next_readdata[`SSR_ADC2_LSB +: SAMPLE_W] =
               slot_adc2[csr.address[`SSR_SLOT_IDX_W-1:0]]; // see R3
         end
      end else if (hit_enable) begin
         next_readdata[`SSR_BIT_DONE] = block_done_enable;
      end else if (hit_status) begin
         next_readdata[`SSR_BIT_DONE] = block_done_flag; // see R6
      end
   end

   // One cycle read latency; data holds until the next read
   // A read beside an enable write returns the old enable
   always_ff @(posedge sys_clk) begin
      if (!srst_n) begin
         readdata <= '0;
      end else if (csr.read) begin // see R8
         readdata <= next_readdata;
      end
   end

   // One clock domain, so one default clock and disable for all checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!srst_n);

   AST_IRQ_EXACT: assert property (irq == (block_done_flag & block_done_enable)) // see R11
      else $error("irq differs from flag and enable");

   AST_IRQ_MASKED: assert property (!block_done_enable |-> !irq) // see R5
      else $error("irq raised while enable is clear");

   AST_FLAG_SET: assert property (rsp.valid && rsp.eop |=> block_done_flag) // see R6
      else $error("block done flag not set after end of block");

   AST_FLAG_PULSE: assert property (block_done_flag && !(rsp.valid && rsp.eop) // see R7
                                    |=> !block_done_flag)
      else $error("block done flag lasted beyond one cycle");

   AST_FLAG_RESET: assert property ($past(!srst_n) |-> block_done_flag) // see R7
      else $error("block done flag not one after reset");

   AST_ENABLE_WRITE: assert property (csr.write && csr.address == `SSR_OFF_ENABLE // see R4
                                      |=> block_done_enable == $past(csr.writedata[0]))
      else $error("enable write not taken");

   AST_SLOT_READBACK: assert property (rsp.valid ##1 (csr.read && !rsp.valid // see R1
                                       && csr.address == {1'b0, $past(rsp.slot)})
                                       |=> readdata[11:0] == $past(rsp.adc1, 2))
      else $error("slot read does not return last result");

   AST_SINGLE_ZERO: assert property (!DUAL && csr.read && csr.address <= `SSR_OFF_SLOTN // see R2
                                     |=> readdata[31:12] == 20'h00000)
      else $error("single build slot upper bits not zero");

   AST_DUAL_ZERO: assert property (DUAL && csr.read && csr.address <= `SSR_OFF_SLOTN // see R3
                                   |=> readdata[31:28] == 4'h0 && readdata[15:12] == 4'h0)
      else $error("dual build reserved bits not zero");

   AST_STATUS_READ: assert property (csr.read && csr.address == `SSR_OFF_STATUS // see R6
                                     |=> readdata == {31'h0, $past(block_done_flag)})
      else $error("status read mismatch");

   AST_UNMAPPED: assert property (csr.read && csr.address > `SSR_OFF_STATUS // see R8
                                  |=> readdata == 32'h00000000)
      else $error("unmapped read not zero");

   // Event, hold, reset and readback checks on flag, enable, irq and read data
   AST_FLAG_ONLY_EOP: assert property (!(rsp.valid && rsp.eop) // see R7
                                       |=> !block_done_flag)
      else $error("block done flag set without end of block");

   AST_FLAG_MASKED_SHOWN: assert property (!block_done_enable && rsp.valid && rsp.eop // see R6
                                           && !(csr.write && csr.address == `SSR_OFF_ENABLE)
                                           |=> block_done_flag && !irq)
      else $error("masked end of block not shown in status alone");

   AST_EOP_RAISES_IRQ: assert property (block_done_enable && rsp.valid && rsp.eop // see R11
                                        && !(csr.write && csr.address == `SSR_OFF_ENABLE)
                                        |=> irq)
      else $error("enabled end of block did not raise irq");

   AST_IRQ_NEEDS_EOP: assert property (!(rsp.valid && rsp.eop) |=> !irq) // see R11
      else $error("irq raised without end of block");

   AST_ENABLE_HOLD: assert property (!(csr.write && csr.address == `SSR_OFF_ENABLE) // see R4
                                     |=> $stable(block_done_enable))
      else $error("enable changed without a write");

   AST_ENABLE_READ: assert property (csr.read && csr.address == `SSR_OFF_ENABLE // see R4
                                     |=> readdata == {31'h0, $past(block_done_enable)})
      else $error("enable read mismatch");

   AST_ENABLE_RESET: assert property ($past(!srst_n) |-> !block_done_enable) // see R4
      else $error("enable not zero after reset");

   AST_IRQ_RESET: assert property ($past(!srst_n) |-> !irq) // see R5
      else $error("irq raised right after reset");

   AST_READ_RESET: assert property ($past(!srst_n) |-> readdata == 32'h00000000) // see R8
      else $error("read data not zero after reset");

   AST_READ_HOLD: assert property (!csr.read |=> $stable(readdata)) // see R8
      else $error("read data changed without a read");

   AST_DUAL_READBACK: assert property (DUAL && rsp.valid ##1 (csr.read && !rsp.valid // see R3
                                       && csr.address == {1'b0, $past(rsp.slot)})
                                       |=> readdata[27:16] == $past(rsp.adc2, 2))
      else $error("dual slot read does not return second result");

   AST_CTRL_UPPER_ZERO: assert property (csr.read && (csr.address == `SSR_OFF_ENABLE // see R4
                                         || csr.address == `SSR_OFF_STATUS)
                                         |=> readdata[31:1] == 31'h0)
      else $error("control word upper bits not zero");

   // Main scenarios
   COV_IRQ: cover property (block_done_enable ##1 irq);
   COV_MASKED_DONE: cover property (!block_done_enable && block_done_flag);
   COV_SLOT_READ: cover property (rsp.valid ##1 csr.read && csr.address <= `SSR_OFF_SLOTN);
   COV_ENABLE_WRITE: cover property (csr.write && csr.address == `SSR_OFF_ENABLE);
   COV_STATUS_READ: cover property (csr.read && csr.address == `SSR_OFF_STATUS
                                    && block_done_flag);

endmodule : ssr_sample_store

//--- verification/adc_sample_store_regs_tb_top.sv
// Bench for the sample store bank, single and dual builds side by side.
// Assumes ssr_master drives the register port.
`timescale 1ns/1ps
module adc_sample_store_regs_tb_top;
   import ssr_pkg::*;
   logic         sys_clk, srst_n, irq;
   ssr_csr_req_t csr;
   ssr_rsp_t     rsp;
   logic [31:0]  readdata, rd2, d;
   int           fail_count = 0, tests_run = 0, cyc = 0;
   ssr_sample_store #(.SLOTS(64), .DUAL(1'b0)) dut (.sys_clk(sys_clk), .srst_n(srst_n),
      .csr(csr), .readdata(readdata), .rsp(rsp), .irq(irq));
   ssr_sample_store #(.SLOTS(64), .DUAL(1'b1)) dut_dual (.sys_clk(sys_clk),
      .srst_n(srst_n), .csr(csr), .readdata(rd2), .rsp(rsp), .irq());
   ssr_master m (.sys_clk(sys_clk), .readdata(readdata), .csr(csr));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic summarize;
      if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // Whole run is under a hundred cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic chk_irq(string n, logic e);
      tests_run++;
      if (irq !== e) begin
         fail_count++;
         $display("Error %s exp %b got %b", n, e, irq);
      end
   endtask : chk_irq
   task automatic res(logic [5:0] s, logic [11:0] a1, logic [11:0] a2, logic eop);
      rsp = '{valid: 1'b1, slot: s, adc1: a1, adc2: a2, eop: eop};
      @(posedge sys_clk) #1;
      rsp = '{valid: 1'b0, slot: ~s, adc1: ~a1, adc2: ~a2, eop: 1'b0};
   endtask : res
   task automatic t_reset;
      srst_n = 1'b1;
      m.rd(7'h41, d);
      chk("status_rst", 32'h1, d);
      chk_irq("irq_rst", 1'b0);
      m.rd(7'h40, d);
      chk("enable_rst", 32'h0, d);
      m.rd(7'h41, d);
      chk("status_clr", 32'h0, d);
   endtask : t_reset
   task automatic t_slots;
      for (int i = 0; i < 2; i++) begin
         res(6'(i * 63), 12'habc ^ 12'(i), 12'h5a5, 1'b0);
         m.rd(7'(i * 63), d);
         chk("slot", {20'h0, 12'habc ^ 12'(i)}, d);
         chk("slot_dual", {4'h0, 12'h5a5, 4'h0, 12'habc ^ 12'(i)}, rd2);
         m.wr(7'(i * 63), 32'hffffffff);
         m.rd(7'(i * 63), d);
         chk("slot_ro", {20'h0, 12'habc ^ 12'(i)}, d);
         chk("slot_ro_dual", {4'h0, 12'h5a5, 4'h0, 12'habc ^ 12'(i)}, rd2);
      end
   endtask : t_slots
   task automatic t_enable;
      m.wr(7'h40, 32'hffffffff);
      m.rd(7'h40, d);
      chk("enable", 32'h1, d);
      m.rd(7'h42, d);
      chk("unmapped", 32'h0, d);
   endtask : t_enable
   task automatic t_eop(logic en);
      m.wr(7'h40, {31'h0, en});
      res(6'h3, 12'h123, 12'h321, 1'b1);
      chk_irq("irq_eop", en);
      m.rd(7'h41, d);
      chk("status_eop", 32'h1, d);
      chk_irq("irq_after", 1'b0);
   endtask : t_eop
   // Reset in mid-run, with enable set and a slot filled
   task automatic t_midreset;
      m.wr(7'h40, 32'h1);
      res(6'h3, 12'h777, 12'h777, 1'b0);
      srst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      srst_n = 1'b1;
      m.rd(7'h41, d);
      chk("status_rerst", 32'h1, d);
      chk_irq("irq_rerst", 1'b0);
      m.rd(7'h40, d);
      chk("enable_rerst", 32'h0, d);
      m.rd(7'h3, d);
      chk("slot_rerst", 32'h0, d);
      chk("slot_rerst_dual", 32'h0, rd2);
   endtask : t_midreset
   initial begin
      srst_n = 1'b0;
      rsp = '0;
      repeat (16) @(posedge sys_clk);
      #1;
      t_reset();
      t_slots();
      t_enable();
      t_eop(1'b0);
      t_eop(1'b1);
      t_midreset();
      summarize();
   end
endmodule : adc_sample_store_regs_tb_top

//--- verification/ssr_master.sv
// Bus master model: word reads and writes on the register port.
// Assumes each call starts just after a rising sys_clk edge.
`timescale 1ns/1ps
module ssr_master (
   input  wire logic                 sys_clk,
   input  wire logic [31:0]          readdata,
   output ssr_pkg::ssr_csr_req_t     csr
);
   import ssr_pkg::*;
   initial csr = '0;
   // One strobe cycle per request
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      csr = '{address: a, read: 1'b0, write: 1'b1, writedata: d};
      @(posedge sys_clk) #1;
      // Stale data would hide a missed strobe
      csr = '{address: a, read: 1'b0, write: 1'b0, writedata: ~d};
      // Idle edge keeps back to back strobes apart
      @(posedge sys_clk) #1;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      csr = '{address: a, read: 1'b1, write: 1'b0, writedata: '0};
      @(posedge sys_clk) #1;
      d = readdata;
      csr = '{address: a, read: 1'b0, write: 1'b0, writedata: '0};
      @(posedge sys_clk) #1;
   endtask : rd
endmodule : ssr_master
